// *** hdl/sdc_run_pkg.sv ***
// Shared constants for the sigma-delta converter run control.
package sdc_run_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_ADDR      = 8'h00;
    localparam logic [7:0] SYNC_BUSY_ADDR = 8'h04;
    localparam logic [7:0] STATUS_ADDR    = 8'h08;

    // Primary control register field positions
    localparam int ON_REQ_BIT     = 7;
    localparam int KEEP_BIT       = 6;
    localparam int ENABLE_BIT     = 1;
    localparam int SOFT_RESET_BIT = 0;

    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] ZERO_BYTE  = 8'h00;

    // Synchronisation busy register field positions
    localparam int SYNC_SW_BIT = 0;
    localparam int SYNC_EN_BIT = 1;

    // Status register field positions
    localparam int STATUS_RUN_BIT  = 0;
    localparam int STATUS_REQ_BIT  = 1;
    localparam int STATUS_STBY_BIT = 2;

    // Write-synchronisation latency in clock cycles, and request count
    localparam int SYNC_CYCLES = 3;
    localparam int NUM_REQ     = 4;

endpackage

// *** hdl/sync_if.sv ***
// Handshake between the run control and one write-synchronisation stage.
`timescale 1ns/1ps
interface sync_if;
    logic start;      // Begin a synchronised update
    logic load_value; // Value to apply once synchronised
    logic clear;      // Force applied value to zero at once
    logic busy;       // Synchronisation in progress
    logic value;      // Applied value
    logic done;       // One-cycle pulse when value is applied

    modport owner (output start, output load_value, output clear,
                   input busy, input value, input done);
    modport stage (input start, input load_value, input clear,
                   output busy, output value, output done);
endinterface

// *** hdl/write_sync_stage.sv ***
// Delayed application of one write-synchronised control bit.
`timescale 1ns/1ps
module write_sync_stage #(
    parameter int SYNC_CYCLES = sdc_run_pkg::SYNC_CYCLES
) (
    input  wire logic clk_i,    // Block clock
    input  wire logic resetn_i, // Asynchronous reset, active low
    sync_if.stage     port      // Owner-facing handshake
);
    localparam int CW = (SYNC_CYCLES > 1) ? $clog2(SYNC_CYCLES) : 1;

    // Refuse a latency that the counter cannot serve
    if (SYNC_CYCLES < 1)
    begin : g_bad_sync
        $error("write_sync_stage: SYNC_CYCLES must be at least 1");
    end

    typedef struct packed {
        logic          busy;
        logic [CW-1:0] cnt;
        logic          pending;
        logic          value;
        logic          done;
    } stage_t;

    stage_t st;
    stage_t next_st;

    // Count down, then apply; a start while busy is dropped by design
    always_comb
    begin
        next_st      = st;
        next_st.done = 1'b0;
        if (st.busy)
        begin
            if (st.cnt == '0)
            begin
                next_st.busy  = 1'b0;
                next_st.value = st.pending;
                next_st.done  = 1'b1;
            end
            else
            begin
                next_st.cnt = st.cnt - 1'b1;
            end
        end
        else if (port.start)
        begin
            next_st.busy    = 1'b1;
            next_st.cnt     = CW'(SYNC_CYCLES - 1);
            next_st.pending = port.load_value;
        end
        // Clear beats a start and a pending update, though an update landing in the same cycle still pulses done
        if (port.clear)
        begin
            next_st.busy  = 1'b0;
            next_st.value = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            st <= '0;
        else
            st <= next_st;
    end

    assign port.busy  = st.busy;
    assign port.value = st.value;
    assign port.done  = st.done;
endmodule

// *** hdl/sigma_delta_run_ctrl.sv ***
// Run-state control for the sigma-delta converter with register port.
//
// Functional notes
// - Bit 7 of the control register selects request-driven (1) or continuous (0).
// - Request-driven: converter runs only while some peripheral requests it.
// - Request-driven with no request: converter is held disabled.
// - Continuous: converter runs whenever enabled, requests ignored.
// - Standby with keep-alive set: request-driven behaviour as in active mode.
// - Standby with keep-alive clear: converter forced off, requests ignored.
// - On-request bit takes effect at once, no synchronisation or busy flag.
// - Control register at offset zero, resets to zero; enable, soft reset synchronised.
`timescale 1ns/1ps
module sigma_delta_run_ctrl #(
    parameter int NUM_REQ     = sdc_run_pkg::NUM_REQ,
    parameter int SYNC_CYCLES = sdc_run_pkg::SYNC_CYCLES
) (
    input  wire logic               CLK_I,     // 250 MHz block clock
    input  wire logic               RESETN_I,  // Asynchronous reset, active low
    input  wire logic [7:0]         ADDR_I,    // Register byte address
    input  wire logic [7:0]         WDATA_I,   // Register write data
    input  wire logic               WR_I,      // Write strobe
    input  wire logic               RD_I,      // Read strobe
    output logic      [7:0]         RDATA_O,   // Read data, cycle after strobe
    input  wire logic [NUM_REQ-1:0] REQ_I,     // Peripheral run requests
    input  wire logic               STANDBY_I, // Standby sleep active
    output logic                    RUN_O      // Converter running
);

    // Refuse shapes the logic cannot serve
    if (NUM_REQ < 1)
    begin : g_bad_req
        $error("sigma_delta_run_ctrl: NUM_REQ must be at least 1");
    end
    if (SYNC_CYCLES < 1 || SYNC_CYCLES > 6)
    begin : g_bad_sync
        $error("sigma_delta_run_ctrl: SYNC_CYCLES must be 1 to 6");
    end

    typedef struct packed {
        logic       on_req;  // Request-driven mode selected
        logic       keep;    // Keep running in standby
        logic [7:0] rdata;   // Registered read data
        logic       run;     // Registered run decision
    } ctrl_t;

    ctrl_t st;
    ctrl_t next_st;

    logic ctrl_wr;   // Accepted write to the control register
    logic awake;     // Not forced off by standby
    logic demand;    // Mode and requests allow running
    logic any_req;   // Some peripheral is requesting

    sync_if en_if ();
    sync_if sw_if ();

    // Enable bit: applied only after synchronisation
    write_sync_stage #(
        .SYNC_CYCLES (SYNC_CYCLES)
    ) u_enable_sync (
        .clk_i    (CLK_I),
        .resetn_i (RESETN_I),
        .port     (en_if)
    );

    // Soft reset: the reset lands when its synchronisation completes
    write_sync_stage #(
        .SYNC_CYCLES (SYNC_CYCLES)
    ) u_soft_reset_sync (
        .clk_i    (CLK_I),
        .resetn_i (RESETN_I),
        .port     (sw_if)
    );

    // Next-state logic: register writes, soft reset, run decision, read mux
    always_comb
    begin
        next_st = st;
        any_req = |REQ_I;
        // Writes are refused while a soft reset is in flight or landing, since the
        // landing reset would otherwise overwrite them in the same cycle
        ctrl_wr = WR_I && (ADDR_I == sdc_run_pkg::CTRL_ADDR) && !sw_if.busy && !sw_if.done;

        en_if.start      = 1'b0;
        en_if.load_value = WDATA_I[sdc_run_pkg::ENABLE_BIT];
        en_if.clear      = sw_if.done;
        sw_if.start      = 1'b0;
        sw_if.load_value = 1'b1;
        sw_if.clear      = 1'b0;

        if (ctrl_wr)
        begin
            next_st.on_req = WDATA_I[sdc_run_pkg::ON_REQ_BIT];
            next_st.keep   = WDATA_I[sdc_run_pkg::KEEP_BIT];
            // Only a real change of enable starts a synchronisation
            if (WDATA_I[sdc_run_pkg::ENABLE_BIT] != en_if.value && !en_if.busy)
                en_if.start = 1'b1;
            if (WDATA_I[sdc_run_pkg::SOFT_RESET_BIT])
                sw_if.start = 1'b1;
        end

        // Soft reset completion returns the register to its reset value
        if (sw_if.done)
        begin
            next_st.on_req = sdc_run_pkg::CTRL_RESET[sdc_run_pkg::ON_REQ_BIT];
            next_st.keep   = sdc_run_pkg::CTRL_RESET[sdc_run_pkg::KEEP_BIT];
        end

        // Standby forces off unless keep-alive is set
        awake  = !STANDBY_I || st.keep;
        // Continuous mode ignores requests; request mode needs one
        demand = !st.on_req || any_req;
        next_st.run = en_if.value && awake && demand;

        // Read mux; unmapped addresses read as zero
        next_st.rdata = sdc_run_pkg::ZERO_BYTE;
        if (RD_I)
        begin
            case (ADDR_I)
                sdc_run_pkg::CTRL_ADDR:
                begin
                    next_st.rdata[sdc_run_pkg::ON_REQ_BIT]     = st.on_req;
                    next_st.rdata[sdc_run_pkg::KEEP_BIT]       = st.keep;
                    next_st.rdata[sdc_run_pkg::ENABLE_BIT]     = en_if.value;
                    next_st.rdata[sdc_run_pkg::SOFT_RESET_BIT] = sw_if.busy;
                end
                sdc_run_pkg::SYNC_BUSY_ADDR:
                begin
                    next_st.rdata[sdc_run_pkg::SYNC_SW_BIT] = sw_if.busy;
                    next_st.rdata[sdc_run_pkg::SYNC_EN_BIT] = en_if.busy;
                end
                sdc_run_pkg::STATUS_ADDR:
                begin
                    next_st.rdata[sdc_run_pkg::STATUS_RUN_BIT]  = st.run;
                    next_st.rdata[sdc_run_pkg::STATUS_REQ_BIT]  = any_req;
                    next_st.rdata[sdc_run_pkg::STATUS_STBY_BIT] = STANDBY_I;
                end
                default:
                begin
                    next_st.rdata = sdc_run_pkg::ZERO_BYTE;
                end
            endcase
        end
    end

    // State register; reset loads constants only
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            st.on_req <= sdc_run_pkg::CTRL_RESET[sdc_run_pkg::ON_REQ_BIT];
            st.keep   <= sdc_run_pkg::CTRL_RESET[sdc_run_pkg::KEEP_BIT];
            st.rdata  <= sdc_run_pkg::ZERO_BYTE;
            st.run    <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    assign RDATA_O = st.rdata;
    assign RUN_O   = st.run;

    // Checks next to the logic they guard
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RESETN_I);

    // Write of the control register followed at once by its read
    sequence s_ctrl_write_read;
        ctrl_wr ##1 (RD_I && ADDR_I == sdc_run_pkg::CTRL_ADDR);
    endsequence

    // Soft reset request accepted, then its synchronisation completes
    sequence s_soft_reset_flight;
        sw_if.busy ##[1:8] sw_if.done;
    endsequence

    property p_mode_readback;
        logic b;
        (s_ctrl_write_read, b = $past(WDATA_I[sdc_run_pkg::ON_REQ_BIT]))
            |=> RDATA_O[sdc_run_pkg::ON_REQ_BIT] == b;
    endproperty
    a_mode_readback: assert property (p_mode_readback)
        else $error("mode bit readback differs from written value");

    property p_run_on_request;
        (en_if.value && st.on_req && awake && any_req) |=> RUN_O;
    endproperty
    a_run_on_request: assert property (p_run_on_request)
        else $error("requested converter did not run");

    property p_stop_without_request;
        (st.on_req && !any_req) |=> !RUN_O;
    endproperty
    a_stop_without_request: assert property (p_stop_without_request)
        else $error("converter ran in request mode with no request");

    property p_continuous_run;
        (en_if.value && !st.on_req && !STANDBY_I) |=> RUN_O;
    endproperty
    a_continuous_run: assert property (p_continuous_run)
        else $error("enabled converter stopped in continuous mode");

    property p_standby_keep;
        (STANDBY_I && st.keep && en_if.value && st.on_req)
            |=> (RUN_O == $past(any_req));
    endproperty
    a_standby_keep: assert property (p_standby_keep)
        else $error("standby with keep-alive broke request behaviour");

    property p_standby_off;
        (STANDBY_I && !st.keep) |=> !RUN_O;
    endproperty
    a_standby_off: assert property (p_standby_off)
        else $error("converter ran in standby without keep-alive");

    property p_mode_no_sync;
        (ctrl_wr && !en_if.busy && !WDATA_I[sdc_run_pkg::SOFT_RESET_BIT]
            && WDATA_I[sdc_run_pkg::ENABLE_BIT] == en_if.value)
            |=> (st.on_req == $past(WDATA_I[sdc_run_pkg::ON_REQ_BIT])
                 && !en_if.busy && !sw_if.busy);
    endproperty
    a_mode_no_sync: assert property (p_mode_no_sync)
        else $error("mode bit write was delayed or raised busy");

    property p_enable_sync;
        (ctrl_wr && !en_if.busy && !WDATA_I[sdc_run_pkg::SOFT_RESET_BIT]
            && WDATA_I[sdc_run_pkg::ENABLE_BIT] != en_if.value)
            |=> en_if.busy ##[1:8] (!en_if.busy && en_if.value != $past(en_if.value, 2));
    endproperty
    a_enable_sync: assert property (p_enable_sync)
        else $error("enable change not applied after synchronisation");

    property p_soft_reset;
        (ctrl_wr && WDATA_I[sdc_run_pkg::SOFT_RESET_BIT])
            |=> s_soft_reset_flight ##1 (!st.on_req && !st.keep && !en_if.value);
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("soft reset did not clear the control register");

    property p_disabled_off;
        !en_if.value |=> !RUN_O;
    endproperty
    a_disabled_off: assert property (p_disabled_off)
        else $error("converter ran while not enabled");

    // Read data stand for one cycle only, zero otherwise
    property p_read_idle_zero;
        !RD_I |=> RDATA_O == sdc_run_pkg::ZERO_BYTE;
    endproperty
    a_read_idle_zero: assert property (p_read_idle_zero)
        else $error("read data present without a read strobe");

    // Unmapped addresses read as zero
    property p_unmapped_zero;
        (RD_I && ADDR_I != sdc_run_pkg::CTRL_ADDR
            && ADDR_I != sdc_run_pkg::SYNC_BUSY_ADDR
            && ADDR_I != sdc_run_pkg::STATUS_ADDR)
            |=> RDATA_O == sdc_run_pkg::ZERO_BYTE;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero)
        else $error("unmapped address read back non-zero");

    // Control read shows the mode bits as they stand
    property p_ctrl_readback;
        (RD_I && ADDR_I == sdc_run_pkg::CTRL_ADDR)
            |=> (RDATA_O[sdc_run_pkg::ON_REQ_BIT] == $past(st.on_req)
                 && RDATA_O[sdc_run_pkg::KEEP_BIT] == $past(st.keep));
    endproperty
    a_ctrl_readback: assert property (p_ctrl_readback)
        else $error("control read differs from the mode bits");

    // A control write during a soft reset changes nothing
    property p_write_refused;
        (WR_I && ADDR_I == sdc_run_pkg::CTRL_ADDR && sw_if.busy)
            |=> (st.on_req == $past(st.on_req) && st.keep == $past(st.keep)
                 && !$rose(en_if.busy));
    endproperty
    a_write_refused: assert property (p_write_refused)
        else $error("control write took effect during soft reset");

    // Mode bits land on the edge of the write itself
    property p_mode_immediate;
        ctrl_wr |=> (st.on_req == $past(WDATA_I[sdc_run_pkg::ON_REQ_BIT])
                     && st.keep == $past(WDATA_I[sdc_run_pkg::KEEP_BIT]));
    endproperty
    a_mode_immediate: assert property (p_mode_immediate)
        else $error("mode bits not applied at the write edge");

    // Busy flags read back as they stand
    property p_sync_busy_read;
        (RD_I && ADDR_I == sdc_run_pkg::SYNC_BUSY_ADDR)
            |=> (RDATA_O[sdc_run_pkg::SYNC_EN_BIT] == $past(en_if.busy)
                 && RDATA_O[sdc_run_pkg::SYNC_SW_BIT] == $past(sw_if.busy));
    endproperty
    a_sync_busy_read: assert property (p_sync_busy_read)
        else $error("busy read differs from synchroniser state");

    // Enable synchronisation ends within 8 cycles, above the longest latency served
    property p_enable_busy_bounded;
        $rose(en_if.busy) |-> ##[1:8] !en_if.busy;
    endproperty
    a_enable_busy_bounded: assert property (p_enable_busy_bounded)
        else $error("enable synchronisation did not finish");

    // Status read reports run state, live requests and standby
    property p_status_read;
        (RD_I && ADDR_I == sdc_run_pkg::STATUS_ADDR)
            |=> (RDATA_O[sdc_run_pkg::STATUS_RUN_BIT] == $past(RUN_O)
                 && RDATA_O[sdc_run_pkg::STATUS_REQ_BIT] == $past(any_req)
                 && RDATA_O[sdc_run_pkg::STATUS_STBY_BIT] == $past(STANDBY_I));
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read differs from live state");

endmodule

// *** testbench/request_source_model.sv ***
// Behavioural model of the peripherals that ask for the converter.
`timescale 1ns/1ps
module request_source_model #(
    parameter int N = 4
) (
    input  wire logic         clk_i,    // Block clock
    input  wire logic         resetn_i, // Asynchronous reset, active low
    input  wire logic [N-1:0] want_i,   // Requests the bench wants raised
    output logic      [N-1:0] req_o     // Request levels seen by the block
);
    // Registered levels, as peripherals hold them; no glitches between edges
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            req_o <= '0;
        else
            req_o <= want_i;
    end
endmodule

// *** testbench/test_sigma_delta_run_ctrl.sv ***
// Self-checking testbench for the sigma-delta converter run control.
`timescale 1ns/1ps
module test_sigma_delta_run_ctrl;
    localparam int N     = sdc_run_pkg::NUM_REQ;
    localparam int LIMIT = 2000;

    logic         clk;         // Block clock
    logic         resetn;      // Reset, active low
    logic [7:0]   addr;        // Register address
    logic [7:0]   wdata;       // Write data
    logic         wr_s;        // Write strobe
    logic         rd_s;        // Read strobe
    logic [7:0]   rdata;       // Read data
    logic [N-1:0] want;        // Requests asked of the model
    logic [N-1:0] req;         // Requests reaching the block
    logic         standby;     // Standby sleep
    logic         run;         // Converter running
    int           mismatches;
    int           comparisons;
    int           cycles;

    sigma_delta_run_ctrl #(.NUM_REQ(N), .SYNC_CYCLES(3)) DUT (
        .CLK_I(clk), .RESETN_I(resetn), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .REQ_I(req),
        .STANDBY_I(standby), .RUN_O(run));

    request_source_model #(.N(N)) peers (
        .clk_i(clk), .resetn_i(resetn), .want_i(want), .req_o(req));

    // 250 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Hang guard: a run far beyond the expected length counts as a mismatch
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge clk);
        wr_s  <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        check(rdata, exp);
    endtask

    // Requests pass the model, then one register stage to the run output
    task automatic apply(input logic [N-1:0] r, input logic s, input logic exp);
        @(posedge clk);
        want    <= r;
        standby <= s;
        settle(3);
        check({7'h00, run}, {7'h00, exp});
    endtask

    initial
    begin
        resetn = 1'b0; addr = 8'h00; wdata = 8'h00; wr_s = 1'b0; rd_s = 1'b0;
        want = '0; standby = 1'b0; mismatches = 0; comparisons = 0; cycles = 0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        rd(sdc_run_pkg::CTRL_ADDR, sdc_run_pkg::CTRL_RESET);
        rd(8'h10, sdc_run_pkg::ZERO_BYTE);
        apply('1, 1'b0, 1'b0);
        // Enable goes through the synchroniser; busy shows meanwhile
        wr(sdc_run_pkg::CTRL_ADDR, 8'h02);
        rd(sdc_run_pkg::SYNC_BUSY_ADDR, 8'h02);
        settle(6);
        rd(sdc_run_pkg::CTRL_ADDR, 8'h02);
        apply('1, 1'b0, 1'b1);
        apply('0, 1'b0, 1'b1);
        // Mode bit is immediate: readable at once, no busy flag
        wr(sdc_run_pkg::CTRL_ADDR, 8'h82);
        rd(sdc_run_pkg::CTRL_ADDR, 8'h82);
        rd(sdc_run_pkg::SYNC_BUSY_ADDR, 8'h00);
        apply('0, 1'b0, 1'b0);
        for (int i = 0; i < N; i++)
        begin
            apply(N'(1) << i, 1'b0, 1'b1);
            apply('0, 1'b0, 1'b0);
        end
        apply('1, 1'b1, 1'b0);
        rd(sdc_run_pkg::STATUS_ADDR, 8'h06);
        wr(sdc_run_pkg::CTRL_ADDR, 8'hc2);
        apply('1, 1'b1, 1'b1);
        rd(sdc_run_pkg::STATUS_ADDR, 8'h07);
        apply('0, 1'b1, 1'b0);
        // Back to continuous mode leaves requests without effect
        wr(sdc_run_pkg::CTRL_ADDR, 8'h02);
        apply('0, 1'b0, 1'b1);
        // Disable wins over every request
        wr(sdc_run_pkg::CTRL_ADDR, 8'hc0);
        settle(6);
        rd(sdc_run_pkg::CTRL_ADDR, 8'hc0);
        apply('1, 1'b0, 1'b0);
        // Soft reset is synchronised, clears set bits, refuses writes on its way
        wr(sdc_run_pkg::CTRL_ADDR, 8'hc2);
        settle(6);
        wr(sdc_run_pkg::CTRL_ADDR, 8'hc3);
        rd(sdc_run_pkg::SYNC_BUSY_ADDR, 8'h01);
        wr(sdc_run_pkg::CTRL_ADDR, 8'h80);
        settle(6);
        rd(sdc_run_pkg::CTRL_ADDR, sdc_run_pkg::CTRL_RESET);
        apply('1, 1'b0, 1'b0);
        print_verdict();
    end
endmodule
